/* temp_sensor_defines.vh */
/*
 Constants of the two-channel temperature sensor register block:
 command codes, field positions, reset values and timing figures.
 Assumes a 250 MHz system clock; included by the design file only.
*/
// Overview of operation
// - Write Byte stores data at commanded register
// - Read Byte returns selected register, host NACKs
// - Send Byte carries command only, starts single-shot
// - Receive Byte returns last commanded register
// - Command pointer resets to zero
// - Main results unsigned, negatives read zero
// - Fraction bits sit in top two positions
// - Main and fraction bytes update together
// - Alarm when temperature at or above limit
// - Limits reset to 70 and 120 degrees
// - Diode fault loads all ones, sets bit 2
// - Diode fault after first conversion, never alerts
// - Alert latched; cleared by response, or by status read once fault gone
// - Alert reasserts after next cycle if persisting
// - Alert response answers with own address
// - Arbitration loser keeps alert, no acknowledge
// - Config bit 7 masks alert, bit 6 standby
// - Config bit 5 converts remote channel only
// - Config bit 4 requires two consecutive faults
// - Status bits: busy, local, remote, open
// - Status read clears flags unless fault persists
// - Single-shot only from standby, when idle
// - Standby aborts conversion without result update
// - Serial interface resets on long clock low
// - Autonomous conversion at four cycles per second, eight in remote-only mode
`ifndef TEMP_SENSOR_DEFINES_VH
`define TEMP_SENSOR_DEFINES_VH

`define CMD_LOCAL_TEMP     8'h00
`define CMD_REMOTE_TEMP    8'h01
`define CMD_STATUS         8'h02
`define CMD_CFG_READ       8'h03
`define CMD_LLIM_READ      8'h05
`define CMD_RLIM_READ      8'h07
`define CMD_CFG_WRITE      8'h09
`define CMD_LLIM_WRITE     8'h0b
`define CMD_RLIM_WRITE     8'h0d
`define CMD_ONE_SHOT       8'h0f
`define CMD_REMOTE_FRAC    8'h10
`define CMD_LOCAL_FRAC     8'h11
`define CMD_MAKER_ID       8'hfe

`define RST_POINTER        8'h00
`define RST_TEMP           8'h00
`define RST_CONFIG         8'h10
`define RST_LOCAL_LIMIT    8'h46
`define RST_REMOTE_LIMIT   8'h78
`define CFG_WRITE_MASK     8'hf0
`define FAULT_TEMP         8'hff

`define CFG_MASK_BIT       7
`define CFG_STANDBY_BIT    6
`define CFG_REMOTE_ONLY    5
`define CFG_QUEUE_BIT      4
`define ST_BUSY_BIT        7
`define ST_LOCAL_BIT       6
`define ST_REMOTE_BIT      4
`define ST_OPEN_BIT        2

`define ALERT_RESP_ADDR    7'h0c
`define DEF_SLAVE_ADDR     7'h48

`define CLK_PERIOD_NS      4
`define CONV_TIME_MS       125
`define TIMEOUT_MIN_MS     20

`endif

/* temp_sensor_smbus_alert_regs.v */
/*
 SMBus slave, register bank, conversion sequencer and latched alert of a
 two-channel temperature sensor. Assumes the ADC front end presents
 signed quarter-degree readings and a diode continuity flag on CLK;
 SCLK and SDA are asynchronous pins, SDA and alert are open drain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "temp_sensor_defines.vh"

module temp_sensor_smbus_alert_regs #(
	parameter [6:0]  SLAVE_ADDR     = `DEF_SLAVE_ADDR,
	// Arbitrary identity value
	parameter [7:0]  MAKER_ID       = 8'h5a,
	parameter [24:0] CONV_CYCLES    = (`CONV_TIME_MS * 1000000) / `CLK_PERIOD_NS,
	parameter [24:0] TIMEOUT_CYCLES =
		(`TIMEOUT_MIN_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	input  wire        CLK,
	input  wire        RESET,
	input  wire        CE,
	input  wire        SCLK,
	input  wire        SDA_IN,
	output wire        SDA_OUT,
	output reg         SDA_OE,
	output wire        ALERT_OUT,
	output reg         ALERT_OE,
	input  wire [10:0] LOCAL_TEMP,
	input  wire [10:0] REMOTE_TEMP,
	input  wire        DIODE_FAULT,
	output wire        CONV_BUSY,
	output wire        REMOTE_SELECT
);

	localparam [3:0] S_IDLE = 4'h0;
	localparam [3:0] S_ADDR = 4'h1;
	localparam [3:0] S_AACK = 4'h2;
	localparam [3:0] S_CMD  = 4'h3;
	localparam [3:0] S_CACK = 4'h4;
	localparam [3:0] S_DATA = 4'h5;
	localparam [3:0] S_DACK = 4'h6;
	localparam [3:0] S_TX   = 4'h7;
	localparam [3:0] S_WAIT = 4'h8;

	// Negative readings clamp to zero; result is main byte and two fraction bits
	function [9:0] clamp;
		input [10:0] v;
		begin
			clamp = v[10] ? 10'h000 : v[9:0];
		end
	endfunction

	reg        scl_s1, scl_s2, scl_d;
	reg        sda_s1, sda_s2, sda_d;
	reg [3:0]  state;
	reg [3:0]  bitcnt;
	reg [7:0]  shreg;
	reg [7:0]  txbyte;
	reg [7:0]  pointer;
	reg        is_read;
	reg        ara_mode;
	reg [24:0] to_cnt;
	reg        wr_strobe;
	reg [7:0]  wr_data;
	reg        stat_rd;
	reg        ara_done;
	reg        oneshot_req;
	reg [7:0]  cfg;
	reg [7:0]  local_limit;
	reg [7:0]  remote_limit;
	reg        conv_active;
	reg        conv_single;
	reg        channel;
	reg [24:0] timer;
	reg        cycle_done;
	reg [7:0]  local_main;
	reg [7:0]  local_frac;
	reg [7:0]  remote_main;
	reg [7:0]  remote_frac;
	reg        open_present;
	reg        local_flag;
	reg        remote_flag;
	reg        open_flag;
	reg        fault_prev;
	reg        alert_latch;
	reg [7:0]  rd_byte;

	wire scl_rise = scl_s2 & ~scl_d;
	wire scl_fall = ~scl_s2 & scl_d;
	wire start_cond = scl_s2 & scl_d & sda_d & ~sda_s2;
	wire stop_cond = scl_s2 & scl_d & ~sda_d & sda_s2;
	wire standby = cfg[`CFG_STANDBY_BIT];
	wire remote_only = cfg[`CFG_REMOTE_ONLY];
	wire cond_local = (local_main >= local_limit) & ~remote_only;
	wire cond_remote = (remote_main >= remote_limit) & ~open_present;
	wire fault_now = cond_local | cond_remote;
	wire qualified = fault_now & (~cfg[`CFG_QUEUE_BIT] | fault_prev);
	wire [9:0] local_val = clamp(LOCAL_TEMP);
	wire [9:0] remote_val = clamp(REMOTE_TEMP);
	wire [7:0] status_byte = {conv_active, local_flag, 1'b0, remote_flag,
		1'b0, open_flag, 2'b00};

	assign SDA_OUT = 1'b0;
	assign ALERT_OUT = 1'b0;
	assign CONV_BUSY = conv_active;
	assign REMOTE_SELECT = channel;

	// Pins cross into CLK through two stages before any decode
	always @(posedge CLK) begin
		if (RESET) begin
			scl_s1 <= 1'b1;
			scl_s2 <= 1'b1;
			scl_d <= 1'b1;
			sda_s1 <= 1'b1;
			sda_s2 <= 1'b1;
			sda_d <= 1'b1;
		end else if (CE) begin
			scl_s1 <= SCLK;
			scl_s2 <= scl_s1;
			scl_d <= scl_s2;
			sda_s1 <= SDA_IN;
			sda_s2 <= sda_s1;
			sda_d <= sda_s2;
		end
	end

	always @* begin
		case (pointer)
			`CMD_LOCAL_TEMP:  rd_byte = local_main;
			`CMD_REMOTE_TEMP: rd_byte = remote_main;
			`CMD_STATUS:      rd_byte = status_byte;
			`CMD_CFG_READ:    rd_byte = cfg;
			`CMD_LLIM_READ:   rd_byte = local_limit;
			`CMD_RLIM_READ:   rd_byte = remote_limit;
			`CMD_REMOTE_FRAC: rd_byte = remote_frac;
			`CMD_LOCAL_FRAC:  rd_byte = local_frac;
			`CMD_MAKER_ID:    rd_byte = MAKER_ID;
			default:          rd_byte = 8'h00;
		endcase
	end

	always @(posedge CLK) begin
		if (RESET) begin
			state <= S_IDLE;
			bitcnt <= 4'h0;
			shreg <= 8'h00;
			txbyte <= 8'h00;
			pointer <= `RST_POINTER;
			is_read <= 1'b0;
			ara_mode <= 1'b0;
			to_cnt <= 25'h0000000;
			SDA_OE <= 1'b0;
			wr_strobe <= 1'b0;
			wr_data <= 8'h00;
			stat_rd <= 1'b0;
			ara_done <= 1'b0;
			oneshot_req <= 1'b0;
		end else if (CE) begin
			wr_strobe <= 1'b0;
			stat_rd <= 1'b0;
			ara_done <= 1'b0;
			oneshot_req <= 1'b0;
			if (scl_s2)
				to_cnt <= 25'h0000000;
			else if (to_cnt != TIMEOUT_CYCLES)
				to_cnt <= to_cnt + 25'h0000001;
			if (!scl_s2 && to_cnt == TIMEOUT_CYCLES - 25'h0000001) begin
				state <= S_IDLE;
				SDA_OE <= 1'b0;
			end else if (start_cond) begin
				state <= S_ADDR;
				bitcnt <= 4'h0;
				SDA_OE <= 1'b0;
			end else if (stop_cond) begin
				state <= S_IDLE;
				SDA_OE <= 1'b0;
			end else begin
				case (state)
					S_ADDR, S_CMD, S_DATA: begin
						if (scl_rise && bitcnt != 4'h8) begin
							shreg <= {shreg[6:0], sda_s2};
							bitcnt <= bitcnt + 4'h1;
						end else if (scl_fall && bitcnt == 4'h8) begin
							bitcnt <= 4'h0;
							if (state == S_ADDR) begin
								if (shreg[7:1] == SLAVE_ADDR) begin
									SDA_OE <= 1'b1;
									is_read <= shreg[0];
									ara_mode <= 1'b0;
									state <= S_AACK;
								end else if (shreg == {`ALERT_RESP_ADDR, 1'b1} && alert_latch) begin
									SDA_OE <= 1'b1;
									is_read <= 1'b1;
									ara_mode <= 1'b1;
									state <= S_AACK;
								end else begin
									state <= S_WAIT;
								end
							end else if (state == S_CMD) begin
								pointer <= shreg;
								oneshot_req <= (shreg == `CMD_ONE_SHOT);
								SDA_OE <= 1'b1;
								state <= S_CACK;
							end else begin
								wr_strobe <= 1'b1;
								wr_data <= shreg;
								SDA_OE <= 1'b1;
								state <= S_DACK;
							end
						end
					end
					S_AACK: begin
						if (scl_fall) begin
							if (is_read) begin
								txbyte <= ara_mode ? {SLAVE_ADDR, 1'b0} : rd_byte;
								SDA_OE <= ara_mode ? ~SLAVE_ADDR[6] : ~rd_byte[7];
								state <= S_TX;
							end else begin
								SDA_OE <= 1'b0;
								state <= S_CMD;
							end
						end
					end
					S_CACK: begin
						if (scl_fall) begin
							SDA_OE <= 1'b0;
							state <= S_DATA;
						end
					end
					S_DACK: begin
						if (scl_fall) begin
							SDA_OE <= 1'b0;
							state <= S_WAIT;
						end
					end
					S_TX: begin
						if (scl_rise) begin
							bitcnt <= bitcnt + 4'h1;
							if (ara_mode && txbyte[7] && !sda_s2) begin
								SDA_OE <= 1'b0;
								state <= S_WAIT;
							end
						end else if (scl_fall && bitcnt == 4'h8) begin
							// Release for master NACK; effects only on whole byte
							SDA_OE <= 1'b0;
							bitcnt <= 4'h0;
							state <= S_WAIT;
							if (ara_mode)
								ara_done <= 1'b1;
							else if (pointer == `CMD_STATUS)
								stat_rd <= 1'b1;
						end else if (scl_fall) begin
							txbyte <= {txbyte[6:0], 1'b0};
							SDA_OE <= ~txbyte[6];
						end
					end
					S_WAIT, S_IDLE: begin
						bitcnt <= 4'h0;
					end
					default: begin
						state <= S_IDLE;
						SDA_OE <= 1'b0;
					end
				endcase
			end
		end
	end

	always @(posedge CLK) begin
		if (RESET) begin
			cfg <= `RST_CONFIG;
			local_limit <= `RST_LOCAL_LIMIT;
			remote_limit <= `RST_REMOTE_LIMIT;
		end else if (CE && wr_strobe) begin
			case (pointer)
				`CMD_CFG_WRITE: cfg <= wr_data & `CFG_WRITE_MASK;
				`CMD_LLIM_WRITE: local_limit <= wr_data;
				`CMD_RLIM_WRITE: remote_limit <= wr_data;
				default: cfg <= cfg;
			endcase
		end
	end

	always @(posedge CLK) begin
		if (RESET) begin
			conv_active <= 1'b0;
			conv_single <= 1'b0;
			channel <= 1'b0;
			timer <= 25'h0000000;
			cycle_done <= 1'b0;
			local_main <= `RST_TEMP;
			local_frac <= `RST_TEMP;
			remote_main <= `RST_TEMP;
			remote_frac <= `RST_TEMP;
			open_present <= 1'b0;
		end else if (CE) begin
			cycle_done <= 1'b0;
			if (!conv_active) begin
				// Autonomous, or single-shot from idle standby
				if (!standby || oneshot_req) begin
					conv_active <= 1'b1;
					conv_single <= standby;
					channel <= remote_only;
					timer <= 25'h0000000;
				end
			end else if (standby && !conv_single) begin
				conv_active <= 1'b0;
				timer <= 25'h0000000;
			end else if (timer == CONV_CYCLES - 25'h0000001) begin
				timer <= 25'h0000000;
				if (!channel) begin
					local_main <= local_val[9:2];
					local_frac <= {local_val[1:0], 6'h00};
					channel <= 1'b1;
				end else begin
					if (DIODE_FAULT) begin
						remote_main <= `FAULT_TEMP;
						remote_frac <= 8'h00;
					end else begin
						remote_main <= remote_val[9:2];
						remote_frac <= {remote_val[1:0], 6'h00};
					end
					open_present <= DIODE_FAULT;
					cycle_done <= 1'b1;
					channel <= remote_only;
					if (conv_single || standby)
						conv_active <= 1'b0;
				end
			end else begin
				timer <= timer + 25'h0000001;
			end
		end
	end

	always @(posedge CLK) begin
		if (RESET) begin
			local_flag <= 1'b0;
			remote_flag <= 1'b0;
			open_flag <= 1'b0;
			fault_prev <= 1'b0;
			alert_latch <= 1'b0;
			ALERT_OE <= 1'b0;
		end else if (CE) begin
			if (cycle_done)
				fault_prev <= fault_now;
			// Flags set win, clear only when cause gone
			local_flag <= (cycle_done & qualified & cond_local)
				| (local_flag & ~(stat_rd & ~cond_local));
			remote_flag <= (cycle_done & qualified & cond_remote)
				| (remote_flag & ~(stat_rd & ~cond_remote));
			// Open reported after a conversion only
			open_flag <= (cycle_done & open_present)
				| (open_flag & ~(stat_rd & ~open_present));
			// Latched alert, reset on response, or on read once fault gone
			alert_latch <= (cycle_done & qualified)
				| (alert_latch & ~(ara_done | (stat_rd & ~fault_now)));
			ALERT_OE <= alert_latch & ~cfg[`CFG_MASK_BIT];
		end
	end

endmodule
`default_nettype wire

/* temp_sensor_sva.sv */
/*
 Pin assertions for the sensor register block.
 Bound to the top module; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_sva #(
	parameter [24:0] TIMEOUT_CYCLES = 25'd400
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic SCLK,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	input wire logic ALERT_OUT,
	input wire logic ALERT_OE,
	input wire logic CONV_BUSY,
	input wire logic REMOTE_SELECT
);
	logic [24:0] low_cnt;
	// Saturates so a stuck-low clock cannot wrap
	always @(posedge CLK) begin
		if (RESET || SCLK)
			low_cnt <= 25'd0;
		else if (low_cnt != TIMEOUT_CYCLES + 25'd16)
			low_cnt <= low_cnt + 25'd1;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	a_pins_open_drain: assert property (!SDA_OUT && !ALERT_OUT)
		else $error("open drain value not zero");
	a_reset_quiet: assert property (
		disable iff (1'b0) RESET |=> !SDA_OE && !ALERT_OE && !CONV_BUSY)
		else $error("outputs active after reset");
	a_conv_autostart: assert property ($fell(RESET) |-> ##[1:2] CONV_BUSY)
		else $error("no conversion after reset");
	a_sda_scl_low: assert property ($changed(SDA_OE) |-> !SCLK)
		else $error("data changed while clock high");
	a_ack_hold: assert property ($rose(SDA_OE) |-> SDA_OE [*3])
		else $error("data drive too short");
	a_alert_after_slot: assert property ($rose(ALERT_OE) |->
		$past(REMOTE_SELECT, 2) || $past(REMOTE_SELECT, 3) || $past(REMOTE_SELECT, 4))
		else $error("alert outside cycle end");
	a_alert_latched: assert property ($rose(ALERT_OE) |-> ALERT_OE [*8])
		else $error("alert not latched");
	a_scl_timeout: assert property (
		low_cnt > TIMEOUT_CYCLES + 25'd8 |-> !SDA_OE)
		else $error("data held past clock timeout");
endmodule
bind temp_sensor_smbus_alert_regs temp_sensor_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_sva (
	.CLK(CLK), .RESET(RESET), .SCLK(SCLK), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
	.ALERT_OUT(ALERT_OUT), .ALERT_OE(ALERT_OE), .CONV_BUSY(CONV_BUSY),
	.REMOTE_SELECT(REMOTE_SELECT)
);
`default_nettype wire

/* smbus_host_model.sv */
/*
 SMBus host master for the sensor bench.
 Assumes the bench clock; SDA has a pull-up, so released reads high.
*/
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
	input  wire logic clk,
	input  wire logic dev_oe,
	output logic      scl,
	output wire logic sda
);
	logic       drv = 1'b0;
	logic [7:0] last;
	int         rx_n = 0;
	assign sda = ~(drv | dev_oe);
	// Clock stands high between frames
	initial scl = 1'b1;
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic bit_io(input logic b, output logic r);
		step(2);
		drv = ~b;
		step(2);
		scl = 1'b1;
		step(4);
		r = sda;
		scl = 1'b0;
	endtask
	task automatic start();
		step(2);
		drv = 1'b0;
		step(2);
		scl = 1'b1;
		step(2);
		drv = 1'b1;
		step(2);
		scl = 1'b0;
	endtask
	task automatic stop();
		step(2);
		drv = 1'b1;
		step(2);
		scl = 1'b1;
		step(2);
		drv = 0;
		step(4);
	endtask
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	// host ends read with no acknowledge
	task automatic get_byte();
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			last[i] = r;
		end
		bit_io(1'b1, r);
		rx_n++;
	endtask
	task automatic write_byte(input logic [6:0] a, input logic [7:0] c, d, input bit has_d,
		output logic ok);
		logic k1, k2, k3;
		start();
		put_byte({a, 1'b0}, k1);
		put_byte(c, k2);
		k3 = 1'b1;
		if (has_d)
			put_byte(d, k3);
		stop();
		ok = k1 & k2 & k3;
	endtask
	task automatic read_byte(input logic [6:0] a, input logic [7:0] c, output logic ok);
		logic k1, k2, k3;
		start();
		put_byte({a, 1'b0}, k1);
		put_byte(c, k2);
		start();
		put_byte({a, 1'b1}, k3);
		get_byte();
		stop();
		ok = k1 & k2 & k3;
	endtask
	task automatic recv_byte(input logic [6:0] a, output logic ok);
		start();
		put_byte({a, 1'b1}, ok);
		get_byte();
		stop();
	endtask
endmodule
`default_nettype wire

/* temp_sensor_smbus_alert_regs_test.sv */
/*
 Self-checking bench for the sensor register block.
 Assumes the host model and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_smbus_alert_regs_test;
	localparam [6:0] SA = 7'h48;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic        ce = 1'b1;
	logic        diode = 1'b0;
	logic [10:0] ltemp = 11'd0;
	logic [10:0] rtemp = 11'd100;
	logic [10:0] v;
	logic        ok;
	logic [15:0] exp_q[$];
	int          miscompares = 0;
	int          n_tests = 0;
	int          seed = 69381;
	wire         scl, sda, sda_oe, alert_oe, busy, sda_out, alert_out, rsel;
	always #2 clk = ~clk;
	smbus_host_model host (.clk(clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
	// Identity value is arbitrary
	temp_sensor_smbus_alert_regs #(
		.MAKER_ID(8'h3c), .CONV_CYCLES(25'd50), .TIMEOUT_CYCLES(25'd400)
	) i_dut (
		.CLK(clk), .RESET(reset), .CE(ce), .SCLK(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
		.SDA_OE(sda_oe), .ALERT_OUT(alert_out), .ALERT_OE(alert_oe), .LOCAL_TEMP(ltemp),
		.REMOTE_TEMP(rtemp), .DIODE_FAULT(diode), .CONV_BUSY(busy), .REMOTE_SELECT(rsel)
	);
	task automatic check(string n, logic [7:0] e, logic [7:0] g, logic [7:0] m);
		n_tests++;
		if ((g & m) !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic flag(string n, logic e, logic g);
		check(n, {7'h00, e}, {7'h00, g}, 8'hff);
	endtask
	always @(host.rx_n) begin
		logic [15:0] e;
		if (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			check("read byte", e[7:0], host.last, e[15:8]);
		end
	end
	task automatic rd(logic [7:0] c, logic [7:0] e, logic [7:0] m = 8'hff);
		exp_q.push_back({m, e & m});
		host.read_byte(SA, c, ok);
		flag("read ack", 1'b1, ok);
	endtask
	task automatic wr(logic [7:0] c, logic [7:0] d, bit has_d = 1'b1);
		host.write_byte(SA, c, d, has_d, ok);
		flag("write ack", 1'b1, ok);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic wait_on(bit a, logic val);
		for (int i = 0; i < 600; i++) begin
			if ((a ? alert_oe : busy) === val)
				return;
			@(posedge clk);
			#1;
		end
		flag("wait limit", val, ~val);
		final_report();
	endtask
	task automatic shot();
		wr(8'h0f, 8'h00, 1'b0);
		wait_on(0, 1'b1);
		wait_on(0, 1'b0);
		#1;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		#1 reset = 1'b0;
		host.step(4);
		exp_q.push_back(16'hff00);
		host.recv_byte(SA, ok);
		flag("receive ack", 1'b1, ok);
		rd(8'h03, 8'h10);
		rd(8'h07, 8'h78);
		rd(8'hfe, 8'h3c);
		rd(8'h02, 8'h00, 8'h7f);
		rd(8'h05, 8'h46);
		exp_q.push_back(16'hff46);
		host.recv_byte(SA, ok);
		flag("pointer receive ack", 1'b1, ok);
		$display("reset test ended");
		wr(8'h09, 8'h4f);
		rd(8'h03, 8'h40);
		v = 11'($random(seed) & 32'h1ff);
		ltemp = v;
		rtemp = 11'h7f0;
		wait_on(0, 1'b0);
		shot();
		repeat (150) @(posedge clk);
		#1;
		flag("idle after shot", 1'b0, busy);
		rd(8'h00, v[9:2]);
		rd(8'h11, {v[1:0], 6'h00}, 8'hc0);
		rd(8'h01, 8'h00);
		rd(8'h10, 8'h00, 8'hc0);
		$display("single shot test ended");
		// Enable low: bus ignored, no conversion starts
		ce = 1'b0;
		host.write_byte(SA, 8'h0f, 8'h00, 1'b0, ok);
		flag("frozen ack", 1'b0, ok);
		flag("frozen busy", 1'b0, busy);
		ce = 1'b1;
		$display("enable test ended");
		ltemp = 11'd200;
		wr(8'h0b, 8'd40);
		shot();
		wait_on(1, 1'b1);
		rd(8'h02, 8'h40, 8'h7f);
		flag("alert kept", 1'b1, alert_oe);
		exp_q.push_back({8'hff, SA, 1'b0});
		host.recv_byte(7'h0c, ok);
		flag("response ack", 1'b1, ok);
		flag("alert cleared", 1'b0, alert_oe);
		shot();
		wait_on(1, 1'b1);
		wr(8'h0b, 8'd60);
		rd(8'h02, 8'h40, 8'h7f);
		flag("alert released", 1'b0, alert_oe);
		exp_q.push_back(16'hffff);
		host.recv_byte(7'h0c, ok);
		flag("idle response ack", 1'b0, ok);
		$display("alert test ended");
		wr(8'h09, 8'h00);
		diode = 1'b1;
		repeat (250) @(posedge clk);
		#1;
		rd(8'h01, 8'hff);
		rd(8'h02, 8'h04, 8'h04);
		flag("no diode alert", 1'b0, alert_oe);
		diode = 1'b0;
		repeat (250) @(posedge clk);
		#1;
		rd(8'h02, 8'h04, 8'h04);
		rd(8'h02, 8'h00, 8'h04);
		$display("diode test ended");
		wr(8'h09, 8'ha0);
		wr(8'h0d, 8'h00);
		// Local input moves only after the last local slot has ended
		ltemp = 11'd40;
		v = 11'($random(seed) & 32'h1ff);
		rtemp = v;
		repeat (250) @(posedge clk);
		#1;
		flag("remote slot only", 1'b1, rsel);
		flag("alert masked", 1'b0, alert_oe);
		rd(8'h00, 8'd50);
		rd(8'h01, v[9:2]);
		rd(8'h10, {v[1:0], 6'h00}, 8'hc0);
		rd(8'h02, 8'h10, 8'h7f);
		$display("mode test ended");
		exp_q.push_back(16'hffff);
		host.read_byte(7'h49, 8'h00, ok);
		flag("foreign address ack", 1'b0, ok);
		rd(8'h05, 8'd60);
		host.start();
		host.put_byte({SA, 1'b1}, ok);
		flag("timeout address ack", 1'b1, ok);
		host.step(4);
		flag("bit driven", 1'b1, sda_oe);
		host.step(450);
		flag("timeout release", 1'b0, sda_oe);
		flag("drive values low", 1'b0, sda_out | alert_out);
		host.stop();
		$display("timeout test ended");
		flag("notes left", 1'b0, exp_q.size() != 0);
		final_report();
	end
endmodule
`default_nettype wire
